// >>> hdl/dac_cfg.svh
`ifndef DAC_CFG_SVH
`define DAC_CFG_SVH
// Register byte offsets
`define DAC_OFS_CTRL 8'h00
`define DAC_OFS_DATA_A 8'h04
`define DAC_OFS_DATA_B 8'h08
`define DAC_OFS_COHERENT 8'h0C
// Control/status field positions
`define DAC_F_MODE_LO 0
`define DAC_F_MODE_HI 3
`define DAC_F_EDGE_POL 4
`define DAC_F_BASE_SEL 5
`define DAC_F_IRQ_EN 6
`define DAC_F_RES_LO 7
`define DAC_F_RES_HI 9
`define DAC_F_FORCE_A 10
`define DAC_F_FORCE_B 11
`define DAC_F_PIN_LEVEL 14
`define DAC_F_FLAG 15
// Mode codes
`define DAC_MODE_DIS 4'h0
`define DAC_MODE_PWIDTH 4'h1
`define DAC_MODE_PERIOD 4'h2
`define DAC_MODE_CAPTURE 4'h3
`define DAC_MODE_OC_B 4'h4
`define DAC_MODE_OC_AB 4'h5
// Reset values
`define DAC_CTRL_RESET 10'h000
`define DAC_DATA_RESET 16'h0000
`endif

// >>> hdl/dac_pkg.sv
package dac_pkg;
  // Software control fields, laid out as in the control register
  typedef struct packed {
    logic [2:0] pwmRes;
    logic irqEn;
    logic baseSel;
    logic edgePol;
    logic [3:0] mode;
  } dac_ctrl_t;
  // APB request group
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } dac_apb_req_t;
  // Capture sequencer, Gray coded along idle, lead, trail
  typedef enum logic [1:0] {
    DAC_ST_IDLE = 2'b00,
    DAC_ST_LEAD = 2'b01,
    DAC_ST_TRAIL = 2'b11,
    DAC_ST_NEXT = 2'b10
  } dac_state_t;
endpackage

// >>> hdl/dac_channel.sv
`timescale 1ns/1ps
`include "dac_cfg.svh"
module dac_channel (
  input wire logic ref_clk, // System clock, 250 MHz
  input wire logic rst_n, // Synchronous reset, active low
  input wire dac_pkg::dac_apb_req_t apbReq, // APB request group
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic [15:0] timeBaseA, // Time base bus A
  input wire logic [15:0] timeBaseB, // Time base bus B
  input wire logic pinIn, // Pin level, asynchronous
  output logic pinOut, // Pin drive level
  output logic pinOe, // Pin output enable, high drives
  output logic irq // Interrupt request
);
  import dac_pkg::*;

  dac_ctrl_t ctrl, next_ctrl;
  dac_state_t state, next_state;
  logic [15:0] regA, regB1, regB2, pendVal;
  logic [15:0] next_regA, next_regB1, next_regB2, next_pendVal;
  logic flag, next_flag, pendXfer, next_pendXfer, pendFlag, next_pendFlag;
  logic armA, armB, next_armA, next_armB, outFf, next_outFf;
  logic s1, s2, s3, syncLevel, next_syncLevel;
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr, next_pinOut, next_pinOe, next_irq;
  logic [15:0] tb, resMask, bRead;
  logic isPwm, isOc, isIn, isMeasure, isDis, cohBusy;
  logic wrEn, setupRd, edgeSeen, edgeSel, edgeOpp, matchA, matchB;
  logic [15:0] pinLvlWord;

  // PWM period mask per resolution code: 7,9,11..16 bits
  function automatic logic [15:0] res_mask(input logic [2:0] r);
    unique case (r)
      3'h0: res_mask = 16'h007F;
      3'h1: res_mask = 16'h01FF;
      3'h2: res_mask = 16'h07FF;
      3'h3: res_mask = 16'h0FFF;
      3'h4: res_mask = 16'h1FFF;
      3'h5: res_mask = 16'h3FFF;
      3'h6: res_mask = 16'h7FFF;
      3'h7: res_mask = 16'hFFFF;
    endcase
  endfunction

  // Pin synchronizer; only the agreed level of stages two and three counts
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
    end else begin
      s1 <= pinIn;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // Mode decode and shared time base
  always_comb begin
    isDis = (ctrl.mode == `DAC_MODE_DIS);
    isPwm = ctrl.mode[3];
    isOc = (ctrl.mode == `DAC_MODE_OC_B) || (ctrl.mode == `DAC_MODE_OC_AB);
    isIn = !isPwm && !isDis && (ctrl.mode[3:2] == 2'b00);
    isMeasure = (ctrl.mode == `DAC_MODE_PWIDTH) || (ctrl.mode == `DAC_MODE_PERIOD);
    tb = ctrl.baseSel ? timeBaseB : timeBaseA;
    resMask = res_mask(ctrl.pwmRes);
    bRead = isPwm ? regB1 : regB2;
    edgeSeen = (s2 == s3) && (s3 != syncLevel);
    edgeSel = edgeSeen && (s3 == ctrl.edgePol);
    edgeOpp = edgeSeen && (s3 != ctrl.edgePol);
    // Compare only the resolution bits in PWM, all 16 bits otherwise
    matchA = isPwm ? ((tb & resMask) == (regA & resMask)) : (armA && tb == regA);
    matchB = isPwm ? ((tb & resMask) == (regB2 & resMask)) : (armB && tb == regB2);
    wrEn = apbReq.psel && apbReq.penable && pready && apbReq.pwrite;
    setupRd = apbReq.psel && !apbReq.penable && !apbReq.pwrite;
    // Busy over the whole coherent read in width and period modes so nothing tears between A and B
    cohBusy = apbReq.psel && !apbReq.pwrite && isMeasure
      && (apbReq.paddr == `DAC_OFS_COHERENT);
    pinLvlWord = 16'h0000;
    pinLvlWord[`DAC_F_PIN_LEVEL] = (isOc || isPwm) ? outFf : syncLevel;
    pinLvlWord[`DAC_F_FLAG] = flag;
  end

  // APB slave: answer one cycle after setup, read data latched at setup
  always_comb begin
    next_pready = apbReq.psel && !apbReq.penable;
    next_prdata = prdata;
    next_pslverr = 1'b0;
    if (apbReq.psel && !apbReq.penable) begin
      next_prdata = 32'h0000_0000;
      unique case (apbReq.paddr)
        `DAC_OFS_CTRL: next_prdata = {16'h0000, pinLvlWord | {6'h00, ctrl}};
        `DAC_OFS_DATA_A: next_prdata = {16'h0000, regA};
        `DAC_OFS_DATA_B: next_prdata = {16'h0000, bRead};
        `DAC_OFS_COHERENT: next_prdata = {regA, bRead};
        default: next_pslverr = 1'b1;
      endcase
    end
    if (!setupRd && !(apbReq.psel && !apbReq.penable)) begin
      next_prdata = prdata;
    end
  end

  // Channel engine: captures, compares, flag and pin
  always_comb begin
    next_ctrl = ctrl;
    next_state = state;
    next_regA = regA;
    next_regB1 = regB1;
    next_regB2 = regB2;
    next_pendVal = pendVal;
    next_pendXfer = pendXfer;
    next_pendFlag = pendFlag;
    next_flag = flag;
    next_armA = armA;
    next_armB = armB;
    next_outFf = outFf;
    next_syncLevel = (s2 == s3) ? s3 : syncLevel;
    // Software writes; hardware events below override, so a hardware flag set beats a software clear
    if (wrEn) begin
      unique case (apbReq.paddr)
        `DAC_OFS_CTRL: begin
          next_ctrl = apbReq.pwdata[9:0];
          if (apbReq.pwdata[`DAC_F_FLAG]) begin
            next_flag = 1'b0;
          end
          if (apbReq.pwdata[`DAC_F_FORCE_A]) begin
            next_outFf = 1'b1; // Force acts like a match, flag untouched
          end
          if (apbReq.pwdata[`DAC_F_FORCE_B]) begin
            next_outFf = 1'b0;
          end
        end
        `DAC_OFS_DATA_A: begin
          next_regA = apbReq.pwdata[15:0];
          next_armA = isOc;
        end
        `DAC_OFS_DATA_B: begin
          if (isDis) begin
            next_regB1 = apbReq.pwdata[15:0];
            next_regB2 = apbReq.pwdata[15:0];
          end else if (isPwm) begin
            next_regB1 = apbReq.pwdata[15:0];
          end else begin
            next_regB2 = apbReq.pwdata[15:0];
          end
          next_armB = isOc;
        end
        default: ;
      endcase
    end
    // Deferred B transfer and flag finish once the coherent read ends
    if (pendXfer && !cohBusy) begin
      next_regB2 = pendVal;
      next_flag = next_flag | pendFlag;
      next_pendXfer = 1'b0;
      next_pendFlag = 1'b0;
    end
    if (isDis) begin
      // Sequencer, flag, arms and pending transfer idle so the next mode starts clean
      next_state = DAC_ST_IDLE;
      next_flag = 1'b0;
      next_armA = 1'b0;
      next_armB = 1'b0;
      next_pendXfer = 1'b0;
      next_pendFlag = 1'b0;
    end else if (ctrl.mode == `DAC_MODE_PWIDTH) begin
      if (state != DAC_ST_TRAIL && edgeSel) begin
        next_regB1 = tb;
        next_state = DAC_ST_TRAIL;
      end else if (state == DAC_ST_TRAIL && edgeOpp) begin
        next_regA = tb;
        next_state = DAC_ST_LEAD;
        if (cohBusy) begin
          next_pendVal = regB1;
          next_pendXfer = 1'b1;
          next_pendFlag = 1'b1;
        end else begin
          next_regB2 = regB1;
          next_flag = 1'b1;
        end
      end
    end else if (isIn && edgeSel) begin
      // Period and plain capture share one path
      next_regA = tb;
      next_regB1 = tb;
      next_state = DAC_ST_NEXT;
      if (cohBusy) begin
        next_pendVal = regB1;
        next_pendXfer = 1'b1;
        next_pendFlag = (state == DAC_ST_NEXT) || (ctrl.mode == `DAC_MODE_CAPTURE);
      end else begin
        next_regB2 = regB1;
        if (state == DAC_ST_NEXT || ctrl.mode == `DAC_MODE_CAPTURE) begin
          next_flag = 1'b1;
        end
      end
    end else if (isOc) begin
      // Equal values fight; the flop then settles low
      if (matchA) begin
        next_outFf = 1'b1;
        next_armA = 1'b0;
      end
      if (matchB) begin
        next_outFf = 1'b0;
        next_armB = 1'b0;
      end
      if (matchB || (matchA && ctrl.mode == `DAC_MODE_OC_AB)) begin
        next_flag = 1'b1;
      end
    end else if (isPwm) begin
      // Period start loads the buffered trailing value, so no glitch mid-period
      if ((tb & resMask) == 16'h0000) begin
        next_regB2 = regB1;
      end
      if (matchA) begin
        next_outFf = 1'b1;
      end
      if (matchB) begin
        next_outFf = 1'b0;
      end
    end
    if (!isOc && !isPwm) begin
      next_outFf = 1'b0;
    end
    next_pinOe = isOc || isPwm;
    next_pinOut = ctrl.edgePol ? next_outFf : !next_outFf;
    next_irq = flag && ctrl.irqEn;
  end

  // State registers
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ctrl <= `DAC_CTRL_RESET;
      state <= DAC_ST_IDLE;
      regA <= `DAC_DATA_RESET;
      regB1 <= `DAC_DATA_RESET;
      regB2 <= `DAC_DATA_RESET;
      pendVal <= `DAC_DATA_RESET;
      pendXfer <= 1'b0;
      pendFlag <= 1'b0;
      flag <= 1'b0;
      armA <= 1'b0;
      armB <= 1'b0;
      outFf <= 1'b0;
      syncLevel <= 1'b0;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      pinOut <= 1'b0;
      pinOe <= 1'b0;
      irq <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      state <= next_state;
      regA <= next_regA;
      regB1 <= next_regB1;
      regB2 <= next_regB2;
      pendVal <= next_pendVal;
      pendXfer <= next_pendXfer;
      pendFlag <= next_pendFlag;
      flag <= next_flag;
      armA <= next_armA;
      armB <= next_armB;
      outFf <= next_outFf;
      syncLevel <= next_syncLevel;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
      pinOut <= next_pinOut;
      pinOe <= next_pinOe;
      irq <= next_irq;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence ocMatchA;
    isOc && armA && (tb == regA) && !(armB && tb == regB2);
  endsequence
  sequence ocMatchB;
    isOc && armB && (tb == regB2);
  endsequence

  a_irq_tracks_flag: assert property (flag && ctrl.irqEn |=> irq)
    else $error("irq not raised for enabled flag");
  a_irq_drops: assert property (!flag |=> !irq)
    else $error("irq without flag");
  a_dis_flag_clear: assert property (isDis |=> !flag)
    else $error("flag set in disabled mode");
  a_dis_no_drive: assert property (isDis && !wrEn |=> !pinOe)
    else $error("pin driven in disabled mode");
  a_oc_sets_out: assert property (ocMatchA |=> outFf && !armA)
    else $error("match A did not set output");
  a_oc_resets_out: assert property (ocMatchB |=> !outFf && !armB)
    else $error("match B did not reset output");
  a_ocb_flag_rule: assert property ((ocMatchA and
    (ctrl.mode == `DAC_MODE_OC_B && !flag && !wrEn)) |=> !flag)
    else $error("flag set on A match in B-only mode");
  a_coh_defers: assert property (cohBusy && !flag && !pendFlag && !wrEn |=> !flag)
    else $error("flag set during coherent read");
  a_apb_ready: assert property (apbReq.psel && !apbReq.penable |=> pready ##1 !pready)
    else $error("pready not a single cycle");
  // Pin follows the flop, inverted when the polarity bit is low
  a_pin_level: assert property (isOc && !wrEn |=> pinOut == (ctrl.edgePol ~^ outFf))
    else $error("pin drive not output flop");
endmodule // dac_channel

// >>> tb/dac_far_model.sv
`timescale 1ns/1ps
module dac_far_model (
  input wire logic ref_clk, // System clock
  input wire logic [15:0] setA, // Count wanted on bus A
  input wire logic [15:0] setB, // Count wanted on bus B
  input wire logic extLevel, // Level the outside world drives
  input wire logic pinOut, // Channel pin drive
  input wire logic pinOe, // Channel pin enable
  output logic [15:0] timeBaseA = 16'h0000, // Time base bus A
  output logic [15:0] timeBaseB = 16'h0000, // Time base bus B
  output logic pinIn // Resolved pin level
);
  // Buses change only on the clock, as the host's counters would
  always @(posedge ref_clk) begin
    timeBaseA <= setA;
    timeBaseB <= setB;
  end
  // Outside driver yields while the channel drives, so no contention
  assign pinIn = pinOe ? pinOut : extLevel;
endmodule // dac_far_model

// >>> tb/testbench.sv
`timescale 1ns/1ps
`include "dac_cfg.svh"
module testbench;
  import dac_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  dac_apb_req_t apbReq = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic pinOut;
  logic pinOe;
  logic irq;
  logic pinIn;
  logic [15:0] timeBaseA;
  logic [15:0] timeBaseB;
  logic [15:0] setA = 16'h0000;
  logic [15:0] setB = 16'h0000;
  logic extLevel = 1'b0;
  logic [31:0] q;
  logic e;
  int miscompares = 0;
  int testsRun = 0;

  // Clock, 4 ns period
  always #2 ref_clk = ~ref_clk;

  dac_channel i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .apbReq(apbReq), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .timeBaseA(timeBaseA), .timeBaseB(timeBaseB),
    .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe), .irq(irq));
  dac_far_model i_far (.ref_clk(ref_clk), .setA(setA), .setB(setB), .extLevel(extLevel),
    .pinOut(pinOut), .pinOe(pinOe), .timeBaseA(timeBaseA), .timeBaseB(timeBaseB),
    .pinIn(pinIn));

  // Single place where the run ends
  task finishTest;
    $display("Checks run %0d, mismatches %0d", testsRun, miscompares);
    if (miscompares == 0 && testsRun > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    testsRun++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One APB transfer; request held until pready is seen at an edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge ref_clk);
    apbReq.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    chk("apb ready", 32'h1, {31'h0, pready});
    q = prdata;
    e = pslverr;
    apbReq.psel <= 1'b0;
    apbReq.penable <= 1'b0;
  endtask

  task chkRd(input string what, input logic [7:0] a, input logic [31:0] m,
    input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(what, exp, q & m);
  endtask

  // Pin change, then time for synchronizer and capture to land
  task pin(input logic lv);
    @(posedge ref_clk);
    extLevel <= lv;
    repeat (10) @(posedge ref_clk);
  endtask

  task setTb(input logic [15:0] a, input logic [15:0] b);
    @(posedge ref_clk);
    setA <= a;
    setB <= b;
    repeat (4) @(posedge ref_clk);
  endtask

  function automatic logic [31:0] cw(input logic [3:0] m, input logic pol, input logic bs,
    input logic ie);
    return {22'h0, 3'h0, ie, bs, pol, m};
  endfunction

  // Watchdog, far beyond the few hundred cycles the tests take
  initial begin
    #200000;
    miscompares++;
    finishTest();
  end

  // Main sequence
  initial begin
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    chkRd("ctrl reset", `DAC_OFS_CTRL, 32'hFFFF, 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, e});
    chk("unmapped data", 32'h0, q);
    apb(1'b1, `DAC_OFS_DATA_B, 32'h1111);
    chkRd("B in disabled", `DAC_OFS_DATA_B, 32'hFFFF, 32'h1111);
    apb(1'b1, `DAC_OFS_DATA_A, 32'h2222);
    chkRd("A in disabled", `DAC_OFS_DATA_A, 32'hFFFF, 32'h2222);
    pin(1'b1);
    chkRd("pin level in", `DAC_OFS_CTRL, 32'h4000, 32'h4000);
    chk("oe disabled", 32'h0, {31'h0, pinOe});
    pin(1'b0);
    // Plain capture, rising edges, interrupt on
    setTb(16'h0100, 16'h0200);
    apb(1'b1, `DAC_OFS_CTRL, cw(4'h3, 1'b1, 1'b0, 1'b1));
    pin(1'b1);
    chkRd("capture A", `DAC_OFS_DATA_A, 32'hFFFF, 32'h0100);
    chkRd("first flag", `DAC_OFS_CTRL, 32'h8000, 32'h8000);
    chk("irq set", 32'h1, {31'h0, irq});
    apb(1'b1, `DAC_OFS_CTRL, cw(4'h3, 1'b1, 1'b1, 1'b1) | 32'h8000);
    chkRd("flag cleared", `DAC_OFS_CTRL, 32'h8000, 32'h0);
    chk("irq clear", 32'h0, {31'h0, irq});
    pin(1'b0);
    chkRd("falling ignored", `DAC_OFS_CTRL, 32'h8000, 32'h0);
    pin(1'b1);
    chkRd("bus B capture", `DAC_OFS_DATA_A, 32'hFFFF, 32'h0200);
    chkRd("B2 holds old", `DAC_OFS_DATA_B, 32'hFFFF, 32'h0100);
    apb(1'b1, `DAC_OFS_CTRL, 32'h0);
    chkRd("flag off", `DAC_OFS_CTRL, 32'h8000, 32'h0);
    // Period, falling edges
    setTb(16'h0300, 16'h0000);
    apb(1'b1, `DAC_OFS_CTRL, cw(4'h2, 1'b0, 1'b0, 1'b0));
    pin(1'b0);
    chkRd("period first", `DAC_OFS_CTRL, 32'h8000, 32'h0);
    setTb(16'h0350, 16'h0000);
    pin(1'b1);
    pin(1'b0);
    chkRd("period pair", `DAC_OFS_COHERENT, 32'hFFFFFFFF, 32'h03500300);
    chkRd("period flag", `DAC_OFS_CTRL, 32'h8000, 32'h8000);
    apb(1'b1, `DAC_OFS_CTRL, 32'h0);
    // Pulse width, rising lead
    setTb(16'h0400, 16'h0000);
    apb(1'b1, `DAC_OFS_CTRL, cw(4'h1, 1'b1, 1'b0, 1'b0));
    pin(1'b1);
    chkRd("width lead", `DAC_OFS_CTRL, 32'h8000, 32'h0);
    setTb(16'h0425, 16'h0000);
    pin(1'b0);
    chkRd("width pair", `DAC_OFS_COHERENT, 32'hFFFFFFFF, 32'h04250400);
    chkRd("width flag", `DAC_OFS_CTRL, 32'h8000, 32'h8000);
    setTb(16'h0000, 16'h0000);
    // Both compare modes, each entered from disabled
    for (int m = 4; m <= 5; m++) begin
      apb(1'b1, `DAC_OFS_CTRL, 32'h0);
      apb(1'b1, `DAC_OFS_CTRL, cw(m[3:0], 1'b1, 1'b0, 1'b0));
      apb(1'b1, `DAC_OFS_DATA_A, 32'h0010);
      apb(1'b1, `DAC_OFS_DATA_B, 32'h0020);
      chk("oe compare", 32'h1, {31'h0, pinOe});
      setTb(16'h0010, 16'h0000);
      chk("match A", 32'h1, {31'h0, pinOut});
      chkRd("flag on A", `DAC_OFS_CTRL, 32'hC000, (m == 5) ? 32'hC000 : 32'h4000);
      setTb(16'h0020, 16'h0000);
      chk("match B", 32'h0, {31'h0, pinOut});
      chkRd("flag on B", `DAC_OFS_CTRL, 32'h8000, 32'h8000);
      setTb(16'h0010, 16'h0000);
      chk("A disarmed", 32'h0, {31'h0, pinOut});
    end
    apb(1'b1, `DAC_OFS_CTRL, 32'h0);
    // PWM at 7 bits; B1 reaches B2 only at a period start
    setTb(16'h0000, 16'h0000);
    apb(1'b1, `DAC_OFS_CTRL, cw(4'hB, 1'b1, 1'b0, 1'b0) | 32'h8000);
    apb(1'b1, `DAC_OFS_DATA_A, 32'h0010);
    apb(1'b1, `DAC_OFS_DATA_B, 32'h0040);
    chk("oe pwm", 32'h1, {31'h0, pinOe});
    setTb(16'h0090, 16'h0000);
    chk("pwm mask set", 32'h1, {31'h0, pinOut});
    apb(1'b1, `DAC_OFS_DATA_B, 32'h0050);
    chkRd("pwm B1", `DAC_OFS_DATA_B, 32'hFFFF, 32'h0050);
    setTb(16'h00C0, 16'h0000);
    chk("pwm buffer", 32'h0, {31'h0, pinOut});
    // Force bits act like matches and leave the flag alone
    apb(1'b1, `DAC_OFS_CTRL, 32'h0);
    apb(1'b1, `DAC_OFS_CTRL, cw(4'h4, 1'b1, 1'b0, 1'b0));
    apb(1'b1, `DAC_OFS_CTRL, cw(4'h4, 1'b1, 1'b0, 1'b0) | 32'h0400);
    chkRd("force A", `DAC_OFS_CTRL, 32'hC000, 32'h4000);
    apb(1'b1, `DAC_OFS_CTRL, cw(4'h4, 1'b0, 1'b0, 1'b0) | 32'h0800);
    chkRd("force B", `DAC_OFS_CTRL, 32'hC000, 32'h0000);
    chk("force B low pol", 32'h1, {31'h0, pinOut});
    apb(1'b1, `DAC_OFS_CTRL, 32'h0);
    finishTest();
  end
endmodule // testbench
